// *** rtl/msc_pkg.sv ***
/*
 Package for the multichip sync controller: register map, field layout,
 reset values and timing constants shared by both ends of the link.
 Assumes a single 40 MHz core clock on each end.
*/
// Notes on behaviour
// RULE1: Host writes 0xc8 for data-rate periodic sync.
// RULE2: Host writes 0x88 for FIFO-rate periodic sync.
// RULE3: Device raises locked; host checks before FIFO reset.
// RULE4: Frame high one data clock resets FIFO.
// RULE5: Data-rate reference is data rate over 2^N.
// RULE6: FIFO-rate reference is data rate over 8*2^N.
// RULE7: Prefer FIFO-rate when exponent is three or more.
// RULE8: Data clock drift stays within one cycle.
// RULE9: Control bit 3 picks rising or falling sample.
// RULE10: Three-bit field averages phase, 1 to 128.
// RULE11: Resync when averaged phase error passes threshold.
// RULE12: Locked after constant phase, bounded alignment time.
// RULE13: Sticky lost bit until register overwritten.
// RULE14: Phase readback in 6.2 format.
// RULE15: Six-bit phase target loaded on initialization.
// RULE16: Host checks event flags before one-time sync.
// RULE17: FIFO-rate lowest rate is data rate over 8.
// RULE18: Clock multiplier mode allows only data-rate sync.
// RULE19: Bit 7 enables, bit 6 selects data-rate mode.
// RULE20: Averaging code k gives 2^k averages.
package msc_pkg;
   localparam logic [7:0] ADDR_CTRL     = 8'h10;
   localparam logic [7:0] ADDR_TARGET   = 8'h11;
   localparam logic [7:0] ADDR_STATUS   = 8'h12;
   localparam logic [7:0] ADDR_READBACK = 8'h13;
   localparam logic [7:0] ADDR_EVENT    = 8'h06;
   localparam logic [7:0] ADDR_HCMD     = 8'h00;
   localparam logic [7:0] ADDR_HSTAT    = 8'h01;
   localparam logic [7:0] ADDR_HCFG     = 8'h02;
   localparam int BIT_ENABLE   = 7;
   localparam int BIT_DATARATE = 6;
   localparam int BIT_RISING   = 3;
   localparam int BIT_LOCKED   = 6;
   localparam int BIT_LOST     = 7;
   localparam int BIT_EV_LOCK  = 4;
   localparam int BIT_EV_LOSS  = 5;
   localparam logic [7:0] CTRL_DATARATE = 8'hc8;
   localparam logic [7:0] CTRL_FIFORATE = 8'h88;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] TARGET_RESET  = 8'h00;
   localparam int NUM_STATES   = 64;
   localparam int FIFO_DEPTH   = 8;
   localparam int LOCK_BASE    = 11;
   localparam int LOCK_STABLE  = 10;
   localparam int PHASE_THRESH = 2;
   localparam int CORE_MHZ     = 40;
   localparam int LINK_DIV_RST = 4;
endpackage : msc_pkg

// *** rtl/msc_link_if.sv ***
/*
 Link between the data source (host) and the sync device: data clock,
 frame and sync reference, plus the device's register port.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface msc_link_if;
   logic       dataClk;
   logic       frame;
   logic       sync_reference_clock;
   logic [7:0] regAddr;
   logic [7:0] regWdata;
   logic       regWr;
   logic       regRd;
   logic [7:0] regRdata;
   modport dev  (input dataClk, frame, sync_reference_clock, regAddr, regWdata, regWr,
                 regRd, output regRdata);
   modport host (output dataClk, frame, sync_reference_clock, regAddr, regWdata, regWr,
                 regRd, input regRdata);
endinterface : msc_link_if
`default_nettype wire

// *** rtl/msc_sync2.sv ***
/*
 Two-flop synchroniser for one level from outside the core clock.
 Assumes nothing besides the core clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_sync2 (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic nrst,
   // Level in and out.
   input  wire logic din,
   output logic      dout
);
   logic stage1Reg;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stage1Reg <= 1'b0;
         dout      <= 1'b0;
      end else begin
         stage1Reg <= din;
         dout      <= stage1Reg;
      end
   end
endmodule : msc_sync2
`default_nettype wire

// *** rtl/msc_device.sv ***
/*
 Device end: samples the sync reference, runs the 64-state clock
 generation counter, averages phase error, reports lock and loss,
 and resets its FIFO pointer on a frame pulse.
 Assumes the host drives the link pins; data clock, frame and reference are synchronised here, the register port is used directly.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_device #(
   parameter int STATES = msc_pkg::NUM_STATES
) (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic nrst,
   // Link.
   msc_link_if.dev   link,
   // Clock source strap: high when the internal multiplier is used.
   input  wire logic pllMode,
   // User-side status.
   output logic      locked,
   output logic      lost,
   output logic      fifoReset,
   output logic [2:0] fifoRdPtr,
   output logic [5:0] clkState
);
   logic       refS, frameS, dclkS, refPrev, framePrev, dclkPrev;
   logic [7:0] ctrlReg, targetReg, rdataReg, eventReg;
   logic       lockedReg, lostReg, everLockedReg, syncedReg;
   logic [5:0] stateReg;
   logic [7:0] avgCntReg, phaseFracReg;
   logic [13:0] accReg, accNext;
   logic [15:0] qAvg;
   logic [3:0] stableReg;
   logic       frameHighReg;
   logic       refRise, refFall, sampleEdge, avgDone, bigErr;
   logic [7:0] avgN;
   logic [5:0] err;
   logic       enable;

   msc_sync2 uRef   (.core_clk(core_clk), .nrst(nrst), .din(link.sync_reference_clock),
                     .dout(refS));
   msc_sync2 uFrame (.core_clk(core_clk), .nrst(nrst), .din(link.frame),
                     .dout(frameS));
   msc_sync2 uDclk  (.core_clk(core_clk), .nrst(nrst), .din(link.dataClk),
                     .dout(dclkS));

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         refPrev   <= 1'b0;
         framePrev <= 1'b0;
         dclkPrev  <= 1'b0;
      end else begin
         refPrev   <= refS;
         framePrev <= frameS;
         dclkPrev  <= dclkS;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // The multiplier clocks only data rate, so FIFO-rate is forced off.
   assign enable  = ctrlReg[msc_pkg::BIT_ENABLE];
   assign refRise = refS & ~refPrev;
   assign refFall = ~refS & refPrev;
   assign sampleEdge = ctrlReg[msc_pkg::BIT_RISING] ?       // RULE9
                       refRise : refFall;
   assign avgN    = 8'h01 << ctrlReg[2:0]; // RULE20
   assign err     = stateReg - targetReg[5:0];
   assign avgDone = enable && sampleEdge &&                 // RULE10
                    (avgCntReg + 8'h01 >= avgN);
   // The closing sample joins the sum, so a window of one sees its error.
   assign accNext = accReg + {8'h00, err};
   assign qAvg    = {accNext, 2'b00} >> ctrlReg[2:0];
   // Errors are wrapped; jitter around zero averages badly when large.
   assign bigErr  = (qAvg[7:2] >= 6'(msc_pkg::PHASE_THRESH)) &&
                    (qAvg[7:2] <= 6'(STATES - msc_pkg::PHASE_THRESH));

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrlReg   <= msc_pkg::CTRL_RESET;
         targetReg <= msc_pkg::TARGET_RESET;
      end else if (link.regWr) begin
         if (link.regAddr == msc_pkg::ADDR_CTRL) begin
            ctrlReg <= link.regWdata;
            if (pllMode)
               ctrlReg[msc_pkg::BIT_DATARATE] <= 1'b1; // RULE18
         end
         if (link.regAddr == msc_pkg::ADDR_TARGET)
            targetReg <= {2'b00, link.regWdata[5:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock generation counter: held at target while disabled, else free runs; loads target + 1 on resync.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stateReg <= 6'h00;
      end else if (!enable) begin
         stateReg <= targetReg[5:0]; // RULE15
      end else if (avgDone && (bigErr || !syncedReg)) begin
         stateReg <= targetReg[5:0] + 6'h01; // RULE11
      end else begin
         stateReg <= stateReg + 6'h01;
      end
   end

   // The first window after enable always reloads the start state.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         syncedReg <= 1'b0;
      end else if (!enable) begin
         syncedReg <= 1'b0;
      end else if (avgDone) begin
         syncedReg <= 1'b1; // RULE15
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         accReg       <= 14'h0000;
         avgCntReg    <= 8'h00;
         phaseFracReg <= 8'h00;
      end else if (!enable) begin
         accReg       <= 14'h0000;
         avgCntReg    <= 8'h00;
      end else if (sampleEdge) begin
         if (avgDone) begin
            avgCntReg    <= 8'h00;
            accReg       <= 14'h0000;
            phaseFracReg <= {stateReg, qAvg[1:0]}; // RULE14
         end else begin
            avgCntReg <= avgCntReg + 8'h01;
            accReg    <= accNext;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lock after several clean averaging windows; lost is sticky.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stableReg     <= 4'h0;
         lockedReg     <= 1'b0;
         everLockedReg <= 1'b0;
         lostReg       <= 1'b0;
      end else begin
         if (!enable) begin
            stableReg <= 4'h0;
            lockedReg <= 1'b0;
         end else if (avgDone) begin
            if (bigErr || !syncedReg) begin
               stableReg <= 4'h0;
               lockedReg <= 1'b0;
            end else if (stableReg == 4'(msc_pkg::LOCK_STABLE)) begin
               lockedReg     <= 1'b1; // RULE12 RULE3
               everLockedReg <= 1'b1;
            end else begin
               stableReg <= stableReg + 4'h1;
            end
         end
         // Set wins over the clearing write.
         if (everLockedReg && lockedReg && avgDone && bigErr)
            lostReg <= 1'b1; // RULE13
         else if (link.regWr && link.regAddr == msc_pkg::ADDR_STATUS)
            lostReg <= link.regWdata[msc_pkg::BIT_LOST];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // FIFO reset on the first data-clock rise seen with frame still high after it rose.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         frameHighReg <= 1'b0;
         fifoReset    <= 1'b0;
         fifoRdPtr    <= 3'h0;
      end else begin
         fifoReset <= 1'b0;
         if (!frameS)
            frameHighReg <= 1'b0;
         else if (frameS && !framePrev)
            frameHighReg <= 1'b1;
         if (frameHighReg && frameS && dclkS && !dclkPrev) begin
            fifoReset    <= 1'b1; // RULE4
            frameHighReg <= 1'b0;
            fifoRdPtr    <= 3'h0;
         end else if (enable && !ctrlReg[msc_pkg::BIT_DATARATE]
                      && dclkS && !dclkPrev) begin
            fifoRdPtr <= fifoRdPtr + 3'h1; // RULE17
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         eventReg <= 8'h00;
      end else begin
         eventReg[msc_pkg::BIT_EV_LOCK] <= refRise |
                                           eventReg[msc_pkg::BIT_EV_LOCK];
         eventReg[msc_pkg::BIT_EV_LOSS] <= lostReg;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdataReg <= 8'h00;
      end else if (link.regRd) begin
         unique case (link.regAddr)
            msc_pkg::ADDR_CTRL:     rdataReg <= ctrlReg;
            msc_pkg::ADDR_TARGET:   rdataReg <= targetReg;
            msc_pkg::ADDR_STATUS:   rdataReg <= {lostReg, lockedReg, 6'h00};
            msc_pkg::ADDR_READBACK: rdataReg <= phaseFracReg;
            msc_pkg::ADDR_EVENT:    rdataReg <= eventReg;
            default:                rdataReg <= 8'h00;
         endcase
      end
   end

   assign link.regRdata = rdataReg;
   assign locked   = lockedReg;
   assign lost     = lostReg;
   assign clkState = stateReg;
endmodule : msc_device
`default_nettype wire

// *** rtl/msc_host.sv ***
/*
 Host end: divides the core clock into the data clock and sync
 reference, pulses frame for one data-clock period, and forwards
 software register accesses to the device.
 Assumes software keeps the rate relations of the reference.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_host (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic nrst,
   // Link.
   msc_link_if.host  link,
   // Software port.
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata
);
   logic [7:0] divReg, divCntReg, refExpReg;
   logic [7:0] refCntReg;
   logic       dclkReg, refReg, frameReg, frameReqReg;
   logic       dclkTick, frameGo;
   logic [7:0] refHalf;

   assign dclkTick = (divCntReg >= divReg);
   // A request waits for the next data clock fall, so none is lost.
   assign frameGo  = dclkTick && dclkReg && frameReqReg && !frameReg;
   // Software keeps the exponent below 3 in data-rate mode. // RULE7
   assign refHalf  = 8'h01 << refExpReg[2:0]; // RULE5 RULE6

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         divReg      <= 8'(msc_pkg::LINK_DIV_RST);
         refExpReg   <= 8'h00;
         frameReqReg <= 1'b0;
      end else begin
         if (wr && addr == msc_pkg::ADDR_HCFG)
            divReg <= (wdata == 8'h00) ? 8'h01 : wdata;
         if (wr && addr == msc_pkg::ADDR_HSTAT)
            refExpReg <= wdata;
         if (wr && addr == msc_pkg::ADDR_HCMD)
            frameReqReg <= 1'b1;
         else if (frameGo)
            frameReqReg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Both link clocks come from the core clock, so drift is nil.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         divCntReg <= 8'h00;
         dclkReg   <= 1'b0;
         refReg    <= 1'b0;
         refCntReg <= 8'h00;
         frameReg  <= 1'b0;
      end else if (dclkTick) begin
         divCntReg <= 8'h00;
         dclkReg   <= ~dclkReg; // RULE8
         if (dclkReg) begin
            if (refCntReg + 8'h01 >= refHalf) begin
               refCntReg <= 8'h00;
               refReg    <= ~refReg;
            end else begin
               refCntReg <= refCntReg + 8'h01;
            end
            // Frame rises on one data clock fall and drops on the next.
            if (frameReg)
               frameReg <= 1'b0;
            else if (frameGo)
               frameReg <= 1'b1; // RULE4
         end
      end else begin
         divCntReg <= divCntReg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register accesses pass through; software checks lock first.
   assign link.dataClk  = dclkReg;
   assign link.sync_reference_clock   = refReg;
   assign link.frame    = frameReg;
   assign link.regAddr  = addr;
   assign link.regWdata = wdata;
   assign link.regWr    = wr && addr[4]; // RULE1 RULE2
   assign link.regRd    = rd &&               // RULE3 RULE16
                          (addr[4] || addr == msc_pkg::ADDR_EVENT);
   assign rdata         = link.regRdata;
endmodule : msc_host
`default_nettype wire

// *** testbench/msc_sync_asserts.sv ***
/*
 Checker for the sync link, watching the interface between both ends.
 Assumes one core clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_sync_asserts (
   // Clock and reset.
   input wire logic       core_clk,
   input wire logic       nrst,
   // Link signals.
   input wire logic       dataClk,
   input wire logic       frame,
   input wire logic       sync_reference_clock,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdata
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrlSh;
   logic [7:0] tgtSh;
   logic       dclkD;
   logic [1:0] frSpan;
   // Shadows mirror writes; the clock-mode strap may force bit 6.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrlSh <= 8'h00;
         tgtSh  <= 8'h00;
         dclkD  <= 1'b0;
         frSpan <= 2'h0;
      end else begin
         dclkD <= dataClk;
         if (regWr && regAddr == msc_pkg::ADDR_CTRL) ctrlSh <= regWdata;
         if (regWr && regAddr == msc_pkg::ADDR_TARGET) tgtSh <= regWdata;
         if (!frame) frSpan <= 2'h0;
         else if (dataClk && !dclkD && frSpan != 2'h3) frSpan <= frSpan + 2'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   AST_STROBE_EXCL: assert property (!(regWr && regRd))
      else $error("read and write strobes together");
   AST_RDATA_HOLD: assert property (!regRd |=> $stable(regRdata))
      else $error("read data changed without a read");
   AST_CTRL_RB: assert property (
      regRd && regAddr == msc_pkg::ADDR_CTRL |=>
      {regRdata[7], regRdata[5:0]} == {ctrlSh[7], ctrlSh[5:0]})
      else $error("control readback differs");
   AST_TGT_RB: assert property (
      regRd && regAddr == msc_pkg::ADDR_TARGET
      |=> regRdata[5:0] == tgtSh[5:0]) else $error("target readback differs");
   AST_STAT_ZERO: assert property (
      regRd && regAddr == msc_pkg::ADDR_STATUS
      |=> regRdata[5:0] == 6'h00) else $error("status low bits set");
   AST_UNMAPPED: assert property (regRd && regAddr[7:4] == 4'h1 &&
      regAddr[3:0] > 4'h3 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   AST_FRAME_SPAN: assert property ($fell(frame) |-> frSpan != 2'h0)
      else $error("frame shorter than a data clock");
   AST_DCLK_RUN: assert property (
      $rose(dataClk) |-> ##[1:520] $fell(dataClk))
      else $error("data clock stalled");
   AST_REF_RUN: assert property (
      $rose(sync_reference_clock) |-> ##[1:1000] $fell(sync_reference_clock))
      else $error("reference stalled");
   cover property ($rose(frame));
   cover property (regRd && regAddr == msc_pkg::ADDR_STATUS ##1 regRdata[6]);
   cover property (regRd && regAddr == msc_pkg::ADDR_STATUS ##1 regRdata[7]);
endmodule : msc_sync_asserts
`default_nettype wire

// *** testbench/msc_tb_top.sv ***
/*
 Testbench joining host and device ends over the link interface.
 Assumes a 40 MHz core clock; the host makes the link clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_tb_top;
   logic        core_clk = 1'b0;
   logic        nrst     = 1'b0;
   logic        pllMode  = 1'b0;
   logic [7:0]  addr     = 8'h00;
   logic [7:0]  wdata    = 8'h00;
   logic        wr       = 1'b0;
   logic        rd       = 1'b0;
   logic [7:0]  rdata;
   logic        locked;
   logic        lost;
   logic        fifoReset;
   logic [15:0] expQ[$];
   logic [15:0] e;
   logic [7:0]  v;
   logic        rdPend   = 1'b0;
   logic        refD     = 1'b0;
   logic [31:0] seed     = 32'h2;
   int          n_fail   = 0;
   int          checked  = 0;
   int          nPulse   = 0;
   int          refPer   = 0;
   int          refCnt   = 0;
   int          frCnt    = 0;
   int          frW      = 0;
   msc_link_if link ();
   msc_host msc_host_i (.core_clk(core_clk), .nrst(nrst), .link(link),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   msc_device msc_device_i (.core_clk(core_clk), .nrst(nrst), .link(link),
      .pllMode(pllMode), .locked(locked), .lost(lost),
      .fifoReset(fifoReset), .fifoRdPtr(), .clkState());
   msc_sync_asserts msc_sync_asserts_i (.core_clk(core_clk), .nrst(nrst),
      .dataClk(link.dataClk), .frame(link.frame), .sync_reference_clock(link.sync_reference_clock),
      .regAddr(link.regAddr), .regWdata(link.regWdata),
      .regWr(link.regWr), .regRd(link.regRd), .regRdata(link.regRdata));
   always #12.5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : nxt
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string msg);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      rd    <= 1'b0;
      @(posedge core_clk);
   endtask : wreg
   // Mask m selects which read bits are judged.
   task automatic rreg(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] d);
      expQ.push_back({m, d});
      addr <= a;
      wr   <= 1'b0;
      rd   <= 1'b1;
      @(posedge core_clk);
   endtask : rreg
   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask : idle
   // Selector: 0 locked, 1 lost, 2 a FIFO reset pulse seen.
   task automatic waitFor(input int sel, input int lim, input string msg);
      int i;
      for (i = 0; i < lim; i++) begin
         if ((sel == 0 && locked === 1'b1) || (sel == 1 && lost === 1'b1)
             || (sel == 2 && nPulse != 0)) break;
         @(posedge core_clk);
      end
      chk({15'h0, i < lim}, 16'h1, msg);
      if (i >= lim) end_sim();
   endtask : waitFor
   ////////////////////////////////////////////////////////////////////////
   // Read data is judged in its one valid cycle, oldest note first.
   always @(posedge core_clk) begin
      rdPend <= rd;
      refD   <= link.sync_reference_clock;
      refCnt <= refCnt + 1;
      frCnt  <= link.frame ? frCnt + 1 : 0;
      if (!link.frame && frCnt != 0) frW <= frCnt;
      if (link.sync_reference_clock && !refD) begin
         refPer <= refCnt + 1;
         refCnt <= 0;
      end
      if (fifoReset === 1'b1) nPulse <= nPulse + 1;
      if (rdPend) begin
         e = expQ.pop_front();
         chk({8'h00, rdata & e[15:8]}, {8'h00, e[7:0] & e[15:8]}, "read");
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      rreg(msc_pkg::ADDR_CTRL, 8'hff, msc_pkg::CTRL_RESET);
      rreg(msc_pkg::ADDR_TARGET, 8'hff, msc_pkg::TARGET_RESET);
      rreg(msc_pkg::ADDR_STATUS, 8'hff, 8'h00);
      wreg(8'h17, nxt());
      rreg(8'h17, 8'hff, 8'h00);
      // Data clock period 8 cycles, reference period 64 cycles.
      wreg(msc_pkg::ADDR_HCFG, 8'h03);
      wreg(msc_pkg::ADDR_HSTAT, 8'h02);
      idle(300);
      $display("Test reset values done");
      chk(16'(refPer), 16'd64, "reference period");
      rreg(msc_pkg::ADDR_EVENT, 8'h10, 8'h10);
      v = nxt() & 8'h3f;
      wreg(msc_pkg::ADDR_TARGET, v);
      wreg(msc_pkg::ADDR_CTRL, msc_pkg::CTRL_DATARATE);
      rreg(msc_pkg::ADDR_CTRL, 8'hff, 8'hc8);
      rreg(msc_pkg::ADDR_TARGET, 8'h3f, v);
      idle(11 * 64 - 16);
      chk({15'h0, locked}, 16'h0, "early lock");
      waitFor(0, 11 * 64 + 16, "lock time");
      rreg(msc_pkg::ADDR_STATUS, 8'hff, 8'h40);
      wreg(msc_pkg::ADDR_HCMD, 8'h01);
      idle(0);
      waitFor(2, 200, "fifo reset");
      idle(40);
      chk(16'(nPulse), 16'd1, "one fifo reset");
      chk(16'(frW), 16'd8, "frame width");
      $display("Test lock and frame done");
      // A 48-cycle reference drifts against the 64-state counter.
      wreg(msc_pkg::ADDR_HCFG, 8'h02);
      idle(0);
      waitFor(1, 3000, "loss");
      wreg(msc_pkg::ADDR_HCFG, 8'h03);
      idle(1600);
      rreg(msc_pkg::ADDR_STATUS, 8'h80, 8'h80);
      rreg(msc_pkg::ADDR_EVENT, 8'h20, 8'h20);
      wreg(msc_pkg::ADDR_STATUS, 8'h00);
      rreg(msc_pkg::ADDR_STATUS, 8'hc0, 8'h40);
      $display("Test loss done");
      wreg(msc_pkg::ADDR_CTRL, 8'h00);
      wreg(msc_pkg::ADDR_CTRL, 8'hc0);
      idle(11 * 64 - 16);
      chk({15'h0, locked}, 16'h0, "early lock on fall");
      waitFor(0, 11 * 64 + 16, "lock on falling edge");
      rreg(msc_pkg::ADDR_READBACK, 8'hff, {v[5:0], 2'b00});
      $display("Test falling edge done");
      pllMode <= 1'b1;
      wreg(msc_pkg::ADDR_CTRL, msc_pkg::CTRL_FIFORATE);
      rreg(msc_pkg::ADDR_CTRL, 8'hff, 8'hc8);
      pllMode <= 1'b0;
      wreg(msc_pkg::ADDR_CTRL, msc_pkg::CTRL_FIFORATE);
      rreg(msc_pkg::ADDR_CTRL, 8'hff, 8'h88);
      for (int k = 0; k < 8; k++) begin
         v = nxt();
         wreg(msc_pkg::ADDR_CTRL, v);
         rreg(msc_pkg::ADDR_CTRL, 8'hff, v);
         wreg(msc_pkg::ADDR_TARGET, v);
         rreg(msc_pkg::ADDR_TARGET, 8'h3f, v);
      end
      idle(4);
      $display("Test modes done");
      end_sim();
   end
endmodule : msc_tb_top
`default_nettype wire
